// file: core/cpsa_pkg.sv
// Purpose: shared constants for the core addressing block
// Assumes: one clock, synchronous active-high reset
// Notes:   pointer space layout chosen for this block
package cpsa_pkg;
  localparam int unsigned PC_W          = 15;
  localparam int unsigned STK_DEPTH     = 16;
  localparam int unsigned PTR_W         = 16;
  localparam int unsigned PMEM_WORDS    = 4096;
  localparam int unsigned PWORD_W       = 14;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned GPR_PER_BANK  = 80;
  localparam int unsigned BANK_SIZE     = 128;
  localparam int unsigned GPR_BASE      = 32;
  localparam int unsigned PROG_SEL_BIT  = 15;
  localparam logic [PC_W-1:0]  RESET_VEC   = 15'h0000;
  localparam logic [PC_W-1:0]  INT_VEC     = 15'h0004;
  localparam logic [PTR_W-1:0] LIN_BASE    = 16'h2000;
  localparam logic [PTR_W-1:0] LIN_LIMIT   = 16'h29b0;
  localparam logic [PTR_W-1:0] EE_BASE     = 16'h7000;
  localparam logic [PTR_W-1:0] EE_LIMIT    = 16'h7100;
  localparam logic [PTR_W-1:0] PTR_RST     = 16'h0000;
  localparam int unsigned SHADOW_W      = 8;
  typedef enum logic [1:0] {
    CPSA_TGT_FILE = 2'b00,
    CPSA_TGT_LIN  = 2'b01,
    CPSA_TGT_EE   = 2'b10,
    CPSA_TGT_PROG = 2'b11
  } cpsa_tgt_e;
  typedef enum logic [1:0] {
    CPSA_PC_RUN  = 2'b00,
    CPSA_PC_WAIT = 2'b01
  } cpsa_pc_e;
endpackage

// file: core/cpsa_stk_if.sv
// Purpose: carries stack requests between the core and the return stack
// Assumes: one clock
// Notes:   push and pop are one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
interface cpsa_stk_if;
  import cpsa_pkg::*;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] push_val;
  logic [PC_W-1:0] top;
  logic            ovf_evt;
  logic            unf_evt;
  logic [4:0]      level;
  modport core (output push, output pop, output push_val, input top, input ovf_evt, input unf_evt, input level);
  modport stk  (input push, input pop, input push_val, output top, output ovf_evt, output unf_evt, output level);
endinterface
`default_nettype wire

// file: core/cpsa_stack.sv
// Purpose: hardware return stack of program counter values
// Assumes: push and pop never both high
// Notes:   full push and empty pop are refused and reported
`timescale 1ns/1ps
`default_nettype none
module cpsa_stack
  import cpsa_pkg::*;
#(
  parameter int unsigned DEPTH = STK_DEPTH
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  cpsa_stk_if.stk   s
);
  logic [PC_W-1:0] mem_q [DEPTH];
  logic [4:0]      lvl_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lvl_q <= 5'h00;
    end else if (s.push && lvl_q != 5'(DEPTH)) begin
      lvl_q <= lvl_q + 5'h01;
    end else if (s.pop && lvl_q != 5'h00) begin
      lvl_q <= lvl_q - 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (s.push && lvl_q != 5'(DEPTH)) begin
      mem_q[lvl_q[3:0]] <= s.push_val;
    end
  end

  assign s.level   = lvl_q;
  assign s.top     = (lvl_q == 5'h00) ? RESET_VEC : mem_q[4'(lvl_q - 5'h01)];
  assign s.ovf_evt = s.push && lvl_q == 5'(DEPTH);
  assign s.unf_evt = s.pop && lvl_q == 5'h00;

  property p_stk_bound;
    @(posedge i_clk) disable iff (i_rst) lvl_q <= 5'(DEPTH);
  endproperty
  a_stk_bound: assert property (p_stk_bound) else $error("stack level beyond depth");
endmodule
`default_nettype wire

// file: core/cpsa_core.sv
// Purpose: program counter, return stack, indirect pointers, shadow context
// Assumes: decoder supplies one-cycle strobes, program memory answers next cycle, data memory during its strobe
// Notes:   stack errors may request a software reset
`timescale 1ns/1ps
`default_nettype none
module cpsa_core
  import cpsa_pkg::*;
#(
  parameter int unsigned PMEM_SIZE = PMEM_WORDS
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_stk_rst_en,
  input  wire logic               i_clr_stk_flags,
  input  wire logic               i_pc_inc,
  input  wire logic               i_pc_load,
  input  wire logic [PC_W-1:0]    i_pc_val,
  input  wire logic               i_call,
  input  wire logic               i_ret,
  input  wire logic               i_int_entry,
  input  wire logic               i_retfie,
  input  wire logic [SHADOW_W*4-1:0] i_ctx,
  input  wire logic               i_ptr_wr,
  input  wire logic               i_ptr_sel,
  input  wire logic [PTR_W-1:0]   i_ptr_val,
  input  wire logic               i_ind_rd,
  input  wire logic               i_ind_wr,
  input  wire logic               i_ind_sel,
  input  wire logic [DATA_W-1:0]  i_ind_wdata,
  input  wire logic [PWORD_W-1:0] i_pmem_rdata,
  input  wire logic [DATA_W-1:0]  i_dmem_rdata,
  output logic [PC_W-1:0]         o_fetch_addr,
  output logic [PC_W-1:0]         o_pc,
  output logic [PTR_W-1:0]        o_ptr0,
  output logic [PTR_W-1:0]        o_ptr1,
  output logic                    o_stack_overflow_flag,
  output logic                    o_stack_underflow_flag,
  output logic                    o_soft_reset,
  output logic                    o_ind_stall,
  output logic                    o_ind_rvalid,
  output logic [DATA_W-1:0]       o_ind_rdata,
  output logic                    o_pmem_rd,
  output logic [PC_W-1:0]         o_pmem_addr,
  output logic                    o_dmem_rd,
  output logic                    o_dmem_wr,
  output logic [1:0]              o_dmem_tgt,
  output logic [PTR_W-1:0]        o_dmem_addr,
  output logic [DATA_W-1:0]       o_dmem_wdata,
  output logic [SHADOW_W*4-1:0]   o_ctx_restore,
  output logic                    o_ctx_restore_vld
);
  localparam logic [PC_W-1:0] PC_MASK = PC_W'(PMEM_SIZE - 1);

  cpsa_stk_if stk ();
  cpsa_stack #(.DEPTH(STK_DEPTH)) u_stack (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .s     (stk.stk)
  );

  logic [PC_W-1:0]  pc_q;
  logic [PC_W-1:0]  pc_d;
  logic [PTR_W-1:0] ptr0_q;
  logic [PTR_W-1:0] ptr1_q;
  logic [PTR_W-1:0] cur_ptr;
  cpsa_tgt_e        tgt;
  cpsa_pc_e         st_q;
  logic             stk_err;

  assign stk.push     = i_call | i_int_entry;
  assign stk.pop      = i_ret | i_retfie;
  assign stk.push_val = pc_q;
  assign stk_err      = stk.ovf_evt | stk.unf_evt;

  always_comb begin
    pc_d = pc_q;
    if (i_int_entry) begin
      pc_d = INT_VEC;
    end else if (stk.pop) begin
      pc_d = stk.top;
    end else if (i_pc_load || i_call) begin
      pc_d = i_pc_val;
    end else if (i_pc_inc && st_q == CPSA_PC_RUN) begin
      pc_d = pc_q + 15'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || o_soft_reset) begin
      pc_q <= RESET_VEC;
    end else begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fetch_addr <= RESET_VEC;
      o_pc         <= RESET_VEC;
    end else begin
      o_fetch_addr <= (o_soft_reset ? RESET_VEC : pc_d) & PC_MASK;
      o_pc         <= o_soft_reset ? RESET_VEC : pc_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_stack_overflow_flag  <= 1'b0;
      o_stack_underflow_flag <= 1'b0;
    end else begin
      o_stack_overflow_flag  <= stk.ovf_evt | (o_stack_overflow_flag & ~i_clr_stk_flags);
      o_stack_underflow_flag <= stk.unf_evt | (o_stack_underflow_flag & ~i_clr_stk_flags);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= stk_err & i_stk_rst_en;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptr0_q <= PTR_RST;
      ptr1_q <= PTR_RST;
    end else if (i_ptr_wr) begin
      if (i_ptr_sel) begin
        ptr1_q <= i_ptr_val;
      end else begin
        ptr0_q <= i_ptr_val;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ptr0 <= PTR_RST;
      o_ptr1 <= PTR_RST;
    end else begin
      o_ptr0 <= (i_ptr_wr && !i_ptr_sel) ? i_ptr_val : ptr0_q;
      o_ptr1 <= (i_ptr_wr && i_ptr_sel) ? i_ptr_val : ptr1_q;
    end
  end

  assign cur_ptr = i_ind_sel ? ptr1_q : ptr0_q;

  always_comb begin
    if (cur_ptr[PROG_SEL_BIT]) begin
      tgt = CPSA_TGT_PROG;
    end else if (cur_ptr >= EE_BASE && cur_ptr < EE_LIMIT) begin
      tgt = CPSA_TGT_EE;
    end else if (cur_ptr >= LIN_BASE && cur_ptr < LIN_LIMIT) begin
      tgt = CPSA_TGT_LIN;
    end else begin
      tgt = CPSA_TGT_FILE;
    end
  end

  // linear offset n maps to bank n/80, byte 32 + n%80
  function automatic logic [PTR_W-1:0] lin_map(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] off;
    logic [PTR_W-1:0] bank;
    off  = p - LIN_BASE;
    bank = off / PTR_W'(GPR_PER_BANK);
    return PTR_W'(bank * PTR_W'(BANK_SIZE)) + PTR_W'(GPR_BASE) + (off - PTR_W'(bank * PTR_W'(GPR_PER_BANK)));
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q         <= CPSA_PC_RUN;
      o_ind_stall  <= 1'b0;
      o_pmem_rd    <= 1'b0;
      o_pmem_addr  <= RESET_VEC;
      o_dmem_rd    <= 1'b0;
      o_dmem_wr    <= 1'b0;
      o_dmem_tgt   <= 2'b00;
      o_dmem_addr  <= PTR_RST;
      o_dmem_wdata <= '0;
    end else begin
      o_pmem_rd <= 1'b0;
      o_dmem_rd <= 1'b0;
      o_dmem_wr <= 1'b0;
      unique case (st_q)
        CPSA_PC_RUN: begin
          if (i_ind_rd && tgt == CPSA_TGT_PROG) begin
            st_q        <= CPSA_PC_WAIT;
            o_ind_stall <= 1'b1;
            o_pmem_rd   <= 1'b1;
            o_pmem_addr <= cur_ptr[PC_W-1:0] & PC_MASK;
          end else if ((i_ind_rd || i_ind_wr) && tgt != CPSA_TGT_PROG) begin
            o_dmem_rd    <= i_ind_rd;
            o_dmem_wr    <= i_ind_wr;
            o_dmem_tgt   <= tgt;
            o_dmem_addr  <= (tgt == CPSA_TGT_LIN) ? lin_map(cur_ptr) : cur_ptr;
            o_dmem_wdata <= i_ind_wdata;
          end
        end
        CPSA_PC_WAIT: begin
          st_q        <= CPSA_PC_RUN;
          o_ind_stall <= 1'b0;
        end
        default: begin
          st_q        <= CPSA_PC_RUN;
          o_ind_stall <= 1'b0;
        end
      endcase
    end
  end

  // read data one cycle after the data strobe, two after the program strobe; program path gives the low byte
  logic prog_wait_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ind_rvalid <= 1'b0;
      o_ind_rdata  <= '0;
      prog_wait_q  <= 1'b0;
    end else begin
      prog_wait_q  <= o_pmem_rd;
      o_ind_rvalid <= prog_wait_q | o_dmem_rd;
      o_ind_rdata  <= prog_wait_q ? i_pmem_rdata[DATA_W-1:0] : i_dmem_rdata;
    end
  end

  logic [SHADOW_W*4-1:0] shadow_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shadow_q          <= '0;
      o_ctx_restore     <= '0;
      o_ctx_restore_vld <= 1'b0;
    end else begin
      if (i_int_entry) begin
        shadow_q <= i_ctx;
      end
      o_ctx_restore_vld <= i_retfie;
      o_ctx_restore     <= i_retfie ? shadow_q : o_ctx_restore;
    end
  end

  property p_int_vec;
    @(posedge i_clk) disable iff (i_rst) i_int_entry && !o_soft_reset |=> o_pc == INT_VEC;
  endproperty
  a_int_vec: assert property (p_int_vec) else $error("interrupt vector not loaded");
  property p_reset_vec;
    @(posedge i_clk) i_rst |=> o_pc == RESET_VEC && !o_stack_overflow_flag;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector not loaded");
  property p_wrap;
    @(posedge i_clk) disable iff (i_rst) o_fetch_addr <= PC_MASK;
  endproperty
  a_wrap: assert property (p_wrap) else $error("fetch outside implemented memory");
  property p_ovf;
    @(posedge i_clk) disable iff (i_rst) stk.push && stk.level == 5'(STK_DEPTH) |=> o_stack_overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missing");
  property p_unf;
    @(posedge i_clk) disable iff (i_rst) stk.pop && stk.level == 5'h00 |=> o_stack_underflow_flag;
  endproperty
  a_unf: assert property (p_unf) else $error("underflow flag missing");
  property p_soft_rst;
    @(posedge i_clk) disable iff (i_rst) stk_err && i_stk_rst_en |=> o_soft_reset ##1 o_pc == RESET_VEC;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("no software reset on stack error");
  property p_no_soft_rst;
    @(posedge i_clk) disable iff (i_rst) !i_stk_rst_en |=> !o_soft_reset;
  endproperty
  a_no_soft_rst: assert property (p_no_soft_rst) else $error("software reset while disabled");
  property p_prog_extra;
    @(posedge i_clk) disable iff (i_rst)
      st_q == CPSA_PC_RUN && i_ind_rd && tgt == CPSA_TGT_PROG |=> o_ind_stall ##1 !o_ind_stall ##1 o_ind_rvalid;
  endproperty
  a_prog_extra: assert property (p_prog_extra) else $error("program read timing wrong");
  property p_prog_nowr;
    @(posedge i_clk) disable iff (i_rst) i_ind_wr && tgt == CPSA_TGT_PROG |=> !o_dmem_wr;
  endproperty
  a_prog_nowr: assert property (p_prog_nowr) else $error("write reached program path");
  property p_ret_addr;
    @(posedge i_clk) disable iff (i_rst)
      i_int_entry && stk.level != 5'(STK_DEPTH) |=> stk.top == $past(pc_q);
  endproperty
  a_ret_addr: assert property (p_ret_addr) else $error("return address not pushed");
  property p_shadow;
    @(posedge i_clk) disable iff (i_rst) i_retfie |=> o_ctx_restore_vld && o_ctx_restore == $past(shadow_q);
  endproperty
  a_shadow: assert property (p_shadow) else $error("context not restored");
  c_int: cover property (@(posedge i_clk) i_int_entry ##[1:20] i_retfie);
  c_ovf: cover property (@(posedge i_clk) stk.ovf_evt);
  c_prog: cover property (@(posedge i_clk) o_pmem_rd);
  c_lin: cover property (@(posedge i_clk) o_dmem_rd && o_dmem_tgt == 2'b01);
endmodule
`default_nettype wire

// file: verif/cpsa_mem_model.sv
// Purpose: program and data memory arrays facing the addressing core
// Assumes: program word follows the read strobe by one cycle; data byte stands during its strobe
// Notes:   idle data lines toggle so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module cpsa_mem_model
  import cpsa_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_pmem_rd,
  input  wire logic [PC_W-1:0]    i_pmem_addr,
  input  wire logic               i_dmem_rd,
  input  wire logic [PTR_W-1:0]   i_dmem_addr,
  output logic [PWORD_W-1:0]      o_pmem_rdata,
  output logic [DATA_W-1:0]       o_dmem_rdata
);
  logic [DATA_W-1:0] didle_q;
  initial begin
    o_pmem_rdata = '0;
    didle_q      = '0;
  end
  // contents are a fixed scramble of the address
  always @(posedge i_clk) begin
    if (i_pmem_rd) o_pmem_rdata <= i_pmem_addr[PWORD_W-1:0] ^ 14'h1a5c;
    else o_pmem_rdata <= ~o_pmem_rdata;
    didle_q <= ~didle_q;
  end
  // the core latches the data byte at the edge that ends its read strobe
  assign o_dmem_rdata = i_dmem_rd ? (i_dmem_addr[DATA_W-1:0] ^ 8'h3c) : didle_q;
endmodule
`default_nettype wire

// file: verif/cpsa_core_tb_top.sv
// Purpose: self-checking bench for the core addressing block
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module cpsa_core_tb_top;
  import cpsa_pkg::*;
  localparam int LD = 0, INC = 1, CALL = 2, RET = 3, INT = 4, RFI = 5, CLR = 6;
  logic i_clk, i_rst, i_stk_rst_en, i_clr_stk_flags, i_pc_inc, i_pc_load, i_call, i_ret;
  logic i_int_entry, i_retfie, i_ptr_wr, i_ptr_sel, i_ind_rd, i_ind_wr, i_ind_sel;
  logic [PC_W-1:0] i_pc_val;
  logic [31:0] i_ctx, ctx_seen;
  logic [PTR_W-1:0] i_ptr_val;
  logic [DATA_W-1:0] i_ind_wdata;
  wire logic [PWORD_W-1:0] pmem_rdata;
  wire logic [DATA_W-1:0] dmem_rdata, o_ind_rdata, o_dmem_wdata;
  wire logic [PC_W-1:0] o_fetch_addr, o_pc, o_pmem_addr;
  wire logic [PTR_W-1:0] o_ptr0, o_ptr1, o_dmem_addr;
  wire logic [1:0] o_dmem_tgt;
  wire logic [31:0] o_ctx_restore;
  wire logic ovf, unf, o_soft_reset, o_ind_stall, o_ind_rvalid, o_pmem_rd, o_dmem_rd, o_dmem_wr, ctx_vld;
  int fails, checks_done, soft_cnt, ctx_cnt;
  cpsa_core uut (.i_clk(i_clk), .i_rst(i_rst), .i_stk_rst_en(i_stk_rst_en), .i_clr_stk_flags(i_clr_stk_flags),
    .i_pc_inc(i_pc_inc), .i_pc_load(i_pc_load), .i_pc_val(i_pc_val), .i_call(i_call), .i_ret(i_ret),
    .i_int_entry(i_int_entry), .i_retfie(i_retfie), .i_ctx(i_ctx), .i_ptr_wr(i_ptr_wr), .i_ptr_sel(i_ptr_sel),
    .i_ptr_val(i_ptr_val), .i_ind_rd(i_ind_rd), .i_ind_wr(i_ind_wr), .i_ind_sel(i_ind_sel),
    .i_ind_wdata(i_ind_wdata), .i_pmem_rdata(pmem_rdata), .i_dmem_rdata(dmem_rdata),
    .o_fetch_addr(o_fetch_addr), .o_pc(o_pc), .o_ptr0(o_ptr0), .o_ptr1(o_ptr1),
    .o_stack_overflow_flag(ovf), .o_stack_underflow_flag(unf), .o_soft_reset(o_soft_reset),
    .o_ind_stall(o_ind_stall), .o_ind_rvalid(o_ind_rvalid), .o_ind_rdata(o_ind_rdata), .o_pmem_rd(o_pmem_rd),
    .o_pmem_addr(o_pmem_addr), .o_dmem_rd(o_dmem_rd), .o_dmem_wr(o_dmem_wr), .o_dmem_tgt(o_dmem_tgt),
    .o_dmem_addr(o_dmem_addr), .o_dmem_wdata(o_dmem_wdata), .o_ctx_restore(o_ctx_restore),
    .o_ctx_restore_vld(ctx_vld));
  cpsa_mem_model mem (.i_clk(i_clk), .i_pmem_rd(o_pmem_rd), .i_pmem_addr(o_pmem_addr), .i_dmem_rd(o_dmem_rd),
    .i_dmem_addr(o_dmem_addr), .o_pmem_rdata(pmem_rdata), .o_dmem_rdata(dmem_rdata));
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_soft_reset === 1'b1) soft_cnt++;
    if (ctx_vld === 1'b1) begin
      ctx_cnt++;
      ctx_seen = o_ctx_restore;
    end
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task step;
    @(posedge i_clk);
    #1;
  endtask
  task automatic op(input int k, input logic [PC_W-1:0] v);
    i_pc_val = v;
    case (k)
      LD: i_pc_load = 1;
      INC: i_pc_inc = 1;
      CALL: i_call = 1;
      RET: i_ret = 1;
      INT: i_int_entry = 1;
      RFI: i_retfie = 1;
      default: i_clr_stk_flags = 1;
    endcase
    step;
    {i_pc_load, i_pc_inc, i_call, i_ret, i_int_entry, i_retfie, i_clr_stk_flags} = '0;
    step;
  endtask
  task setptr(input logic s, input logic [PTR_W-1:0] v);
    i_ptr_sel = s;
    i_ptr_val = v;
    i_ptr_wr = 1;
    step;
    i_ptr_wr = 0;
    step;
  endtask
  task t_pc;
    chk("pc_reset", o_pc, 0);
    op(LD, 15'h0ffe);
    op(INC, 0);
    chk("pc_inc", o_pc, 15'h0fff);
    op(INC, 0);
    chk("pc_over", o_pc, 15'h1000);
    chk("fetch_wrap", o_fetch_addr, 15'h0000);
    op(LD, 15'h7fff);
    chk("pc_top", o_pc, 15'h7fff);
    chk("fetch_top", o_fetch_addr, 15'h0fff);
  endtask
  task t_stack;
    for (int i = 0; i < 16; i++) begin
      op(LD, 15'h0100 + 15'(i));
      op(CALL, 15'h0200 + 15'(i));
      chk("pc_call", o_pc, 15'h0200 + 15'(i));
    end
    chk("ovf_full", ovf, 0);
    op(CALL, 15'h0300);
    chk("ovf_set", ovf, 1);
    chk("soft_off", soft_cnt, 0);
    for (int i = 15; i >= 0; i--) begin
      op(RET, 0);
      chk("pc_ret", o_pc, 15'h0100 + 15'(i));
    end
    chk("unf_clear", unf, 0);
    op(RET, 0);
    chk("unf_set", unf, 1);
    op(CLR, 0);
    chk("flags_clr", {ovf, unf}, 0);
    i_stk_rst_en = 1;
    op(LD, 15'h0055);
    i_ret = 1;
    step;
    {i_ret, i_pc_load, i_pc_val} = {2'b01, 15'h0066};
    step;
    i_pc_load = 0;
    chk("soft_on", soft_cnt, 1);
    chk("pc_soft", o_pc, 0);
    step;
    i_stk_rst_en = 0;
  endtask
  task t_rst;
    op(CALL, 15'h0400);
    setptr(0, 16'h1234);
    i_rst = 1;
    step;
    step;
    i_rst = 0;
    chk("rst_pc", {o_pc, o_fetch_addr}, 0);
    chk("rst_state", {ovf, unf, o_ptr0}, 0);
    op(RET, 0);
    chk("rst_stack", unf, 1);
  endtask
  task t_int;
    op(LD, 15'h0345);
    i_ctx = 32'hc0de5a17;
    op(INT, 0);
    chk("pc_vec", o_pc, 15'h0004);
    i_ctx = 32'h0;
    op(RFI, 0);
    chk("ctx_cnt", ctx_cnt, 1);
    chk("ctx_val", ctx_seen, 32'hc0de5a17);
    chk("pc_back", o_pc, 15'h0345);
  endtask
  task t_ind;
    int n;
    setptr(0, 16'h2050);
    setptr(1, 16'h8123);
    chk("ptr0", o_ptr0, 16'h2050);
    chk("ptr1", o_ptr1, 16'h8123);
    i_ind_sel = 0;
    i_ind_rd = 1;
    step;
    i_ind_rd = 0;
    chk("lin_rd", {o_dmem_rd, o_ind_stall, o_dmem_tgt}, 4'b1001);
    chk("lin_addr", o_dmem_addr, 16'h00a0);
    for (n = 0; n < 5 && o_ind_rvalid !== 1'b1; n++) step;
    chk("lin_data", {o_ind_rvalid, o_ind_rdata}, {1'b1, 8'ha0 ^ 8'h3c});
    step;
    i_ind_sel = 1;
    i_ind_rd = 1;
    step;
    i_ind_rd = 0;
    chk("prog_rd", {o_pmem_rd, o_ind_stall}, 2'b11);
    chk("prog_addr", o_pmem_addr, 15'h0123);
    step;
    chk("prog_c2", {o_ind_stall, o_ind_rvalid}, 2'b00);
    step;
    chk("prog_data", {o_ind_rvalid, o_ind_rdata}, {1'b1, 8'(14'h0123 ^ 14'h1a5c)});
    step;
    i_ind_wr = 1;
    i_ind_wdata = 8'h96;
    step;
    i_ind_wr = 0;
    chk("prog_wr", {o_dmem_wr, o_pmem_rd}, 2'b00);
    step;
    chk("prog_wr2", o_dmem_wr, 0);
    setptr(0, 16'h7010);
    i_ind_sel = 0;
    i_ind_wr = 1;
    step;
    i_ind_wr = 0;
    chk("ee_wr", {o_dmem_wr, o_dmem_tgt, o_dmem_wdata}, {1'b1, 2'b10, 8'h96});
    chk("ee_addr", o_dmem_addr, 16'h7010);
    setptr(1, 16'h0040);
    i_ind_sel = 1;
    i_ind_rd = 1;
    step;
    i_ind_rd = 0;
    chk("file_rd", {o_dmem_rd, o_dmem_tgt}, 3'b100);
    chk("file_addr", o_dmem_addr, 16'h0040);
  endtask
  task results;
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {i_rst, i_stk_rst_en, i_clr_stk_flags, i_pc_inc, i_pc_load, i_call, i_ret} = 7'h40;
    {i_int_entry, i_retfie, i_ptr_wr, i_ptr_sel, i_ind_rd, i_ind_wr, i_ind_sel} = '0;
    i_pc_val = '0;
    i_ctx = '0;
    i_ptr_val = '0;
    i_ind_wdata = '0;
    fails = 0;
    checks_done = 0;
    soft_cnt = 0;
    ctx_cnt = 0;
    repeat (8) @(posedge i_clk);
    #1;
    i_rst = 0;
    t_pc;
    t_stack;
    t_int;
    t_ind;
    t_rst;
    results;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    results;
  end
endmodule
`default_nettype wire
